// file: src/rtc_control_status_trim.sv
/*
 status flags, control, alarm pin, frequency output and trim of the rtc.
 assumes a serial slave on core_clk_i issuing register requests and a
 valid-stop pulse, an alarm comparator pulsing alarm_hit_i, and a free
 running oscillator clock of OSC_HZ on osc_clk_i.
*/
`default_nettype none
`include "rtc_map.svh"
module rtc_control_status_trim
    import rtc_pkg::*;
#(
    parameter int PULSE_CYC = `PULSE_CYC
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic osc_clk_i,
    input wire reg_req_t req_i,
    input wire logic stop_i,
    input wire logic alarm_hit_i,
    input wire supply_t supply_i,
    output logic [7:0] rdata_o,
    output logic rtc_wr_o,
    output logic counting_o,
    output logic osc_disable_o,
    output logic backup_o,
    output logic alarm_en_o,
    output logic [6:0] cap_half_pf_o,
    output logic sec_tick_o,
    output logic pin_o,
    output logic pin_oe_o
);

    if (PULSE_CYC < 1 || PULSE_CYC >= (2 ** `PULSE_W)) begin : g_chk
        $error("PULSE_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] freq_bit(input logic [3:0] s);
        case (s)
            4'h1: freq_bit = 5'h00;
            4'h2: freq_bit = 5'h03;
            4'h3: freq_bit = 5'h05;
            default: freq_bit = {1'b0, s} + 5'h05;
        endcase
    endfunction : freq_bit

    function automatic logic [15:0] trim_period(input logic [1:0] u);
        case (u)
            2'h1: trim_period = 16'(`TRIM_UNIT_CNT);
            2'h2: trim_period = 16'(`TRIM_UNIT_CNT / 2);
            2'h3: trim_period = 16'((`TRIM_UNIT_CNT + 1) / 3);
            default: trim_period = 16'h0000;
        endcase
    endfunction : trim_period

    function automatic logic [6:0] cap_code(input logic [7:0] c, input logic bk);
        logic [6:0] base;
        base = {1'b0, ~c[5], c[4:0]} + 7'(`CAP_BASE_HALF);
        cap_code = base;
        if (bk) begin
            case (c[7:6])
                2'h1: cap_code = base - 7'h01;
                2'h2: cap_code = base + 7'h01;
                2'h3: cap_code = base + 7'h02;
                default: cap_code = base;
            endcase
        end
    endfunction : cap_code

    ////////////////////////////////////////////////////////////////////
    // supply pins into the core domain
    supply_t sup_m_q;
    supply_t sup_s_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sup_m_q <= '0;
            sup_s_q <= '0;
        end else begin
            sup_m_q <= supply_i;
            sup_s_q <= sup_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core control and status
    logic [1:0] boot_q, boot_d;
    logic boot_done_q, boot_done_d;
    logic pf_q, pf_d;
    logic bat_q, bat_d;
    logic match_q, match_d;
    logic wr_en_q, wr_en_d;
    logic osc_off_q, osc_off_d;
    logic auto_q, auto_d;
    logic [7:0] ev_q, ev_d;
    logic [7:0] cap_q, cap_d;
    logic [2:0] rate_q, rate_d;
    logic counting_q, counting_d;
    logic on_backup_q, on_backup_c;
    logic hit_in_read_q, hit_in_read_d;
    logic rl_tog_q, rl_tog_d;
    logic [`PULSE_W-1:0] pulse_q, pulse_d;
    xact_t xact_q, xact_d;
    logic [7:0] rdata_d;
    logic rtc_wr_d;
    logic [6:0] cap_out_d;
    logic alarm_en_c;
    pin_ctl_t pin_ctl_q, pin_ctl_d;
    logic wr_rtc, wr_sr, wr_ev, match_set, bat_set;
    logic stop_rd, stop_wr, clr_bat, clr_match;

    always_comb begin
        wr_rtc = req_i.wr && req_i.addr <= `ADDR_RTC_LAST && wr_en_q;
        wr_sr = req_i.wr && req_i.addr == `ADDR_STATUS;
        wr_ev = req_i.wr && req_i.addr == `ADDR_EVENT;
        on_backup_c = sup_s_q.vdd_below_bat
            && (ev_q[`EV_LOW_PWR] || sup_s_q.vdd_below_trip);
        alarm_en_c = ev_q[`EV_GATE] && ev_q[3:0] == 4'h0;
        match_set = alarm_hit_i && alarm_en_c;
        bat_set = on_backup_c && !on_backup_q;
        stop_rd = stop_i && xact_q == X_RD_SR;
        stop_wr = stop_i && xact_q == X_WR_RTC;
        clr_bat = (wr_sr && !req_i.wdata[`SR_BACKUP])
            || (stop_rd && auto_q);
        clr_match = (wr_sr && !req_i.wdata[`SR_MATCH])
            || (stop_rd && auto_q && !hit_in_read_q);
        boot_d = boot_q;
        boot_done_d = boot_done_q;
        pf_d = pf_q;
        counting_d = counting_q;
        if (!boot_done_q) begin
            boot_d = boot_q + 2'h1;
            if (boot_q == 2'h2) begin
                boot_done_d = 1'b1;
                pf_d = sup_s_q.all_lost;
                counting_d = !sup_s_q.all_lost;
            end
        end
        if (wr_rtc) begin
            pf_d = 1'b0;
        end
        rl_tog_d = rl_tog_q;
        if (stop_wr) begin
            counting_d = 1'b1;
            rl_tog_d = !rl_tog_q;
        end
        bat_d = bat_set || (bat_q && !clr_bat);
        match_d = match_set || (match_q && !clr_match);
        wr_en_d = wr_en_q;
        osc_off_d = osc_off_q;
        auto_d = auto_q;
        if (wr_sr) begin
            wr_en_d = req_i.wdata[`SR_WR_EN];
            osc_off_d = req_i.wdata[`SR_OSC_OFF];
            auto_d = req_i.wdata[`SR_AUTO_CLR];
        end
        ev_d = wr_ev ? req_i.wdata : ev_q;
        cap_d = (req_i.wr && req_i.addr == `ADDR_CAPTRIM) ? req_i.wdata : cap_q;
        rate_d = (req_i.wr && req_i.addr == `ADDR_RATETRIM) ? req_i.wdata[2:0] : rate_q;
        xact_d = xact_q;
        case (xact_q)
            X_IDLE: begin
                if (wr_rtc) begin
                    xact_d = X_WR_RTC;
                end else if (req_i.rd && req_i.addr == `ADDR_STATUS) begin
                    xact_d = X_RD_SR;
                end
            end
            X_RD_SR: begin
                if (stop_i) begin
                    xact_d = X_IDLE;
                end
            end
            X_WR_RTC: begin
                if (stop_i) begin
                    xact_d = X_IDLE;
                end
            end
            default: xact_d = X_IDLE;
        endcase
        hit_in_read_d = (xact_q == X_RD_SR && !stop_i) ? (hit_in_read_q || match_set) : 1'b0;
        pulse_d = pulse_q;
        if (match_set && ev_q[`EV_REPEAT]) begin
            pulse_d = `PULSE_W'(PULSE_CYC);
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - `PULSE_W'(1);
        end
        rdata_d = rdata_o;
        if (req_i.rd) begin
            case (req_i.addr)
                `ADDR_STATUS: rdata_d = {auto_q, osc_off_q, 1'b0, wr_en_q, 1'b0, match_q, bat_q, pf_q};
                `ADDR_EVENT: rdata_d = ev_q;
                `ADDR_CAPTRIM: rdata_d = cap_q;
                `ADDR_RATETRIM: rdata_d = {5'h00, rate_q};
                default: rdata_d = 8'h00;
            endcase
        end
        rtc_wr_d = wr_rtc;
        cap_out_d = cap_code(cap_q, on_backup_q);
        pin_ctl_d.fsel = ev_q[3:0];
        pin_ctl_d.off = ev_q[`EV_PIN_OFF] && on_backup_q;
        pin_ctl_d.lvl = alarm_en_c && (ev_q[`EV_REPEAT] ? pulse_q != '0 : match_q);
        pin_ctl_d.run = counting_q;
        pin_ctl_d.rate = rate_q;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_q <= 2'h0;
            boot_done_q <= 1'b0;
            pf_q <= 1'b0;
            bat_q <= 1'b0;
            match_q <= 1'b0;
            wr_en_q <= 1'b0;
            osc_off_q <= 1'b0;
            auto_q <= 1'b0;
            ev_q <= `REG_RESET;
            cap_q <= `REG_RESET;
            rate_q <= 3'h0;
            counting_q <= 1'b0;
            on_backup_q <= 1'b0;
            hit_in_read_q <= 1'b0;
            rl_tog_q <= 1'b0;
            pulse_q <= '0;
            xact_q <= X_IDLE;
            rdata_o <= 8'h00;
            rtc_wr_o <= 1'b0;
            cap_half_pf_o <= 7'h00;
            pin_ctl_q <= '0;
        end else begin
            boot_q <= boot_d;
            boot_done_q <= boot_done_d;
            pf_q <= pf_d;
            bat_q <= bat_d;
            match_q <= match_d;
            wr_en_q <= wr_en_d;
            osc_off_q <= osc_off_d;
            auto_q <= auto_d;
            ev_q <= ev_d;
            cap_q <= cap_d;
            rate_q <= rate_d;
            counting_q <= counting_d;
            on_backup_q <= on_backup_c;
            hit_in_read_q <= hit_in_read_d;
            rl_tog_q <= rl_tog_d;
            pulse_q <= pulse_d;
            xact_q <= xact_d;
            rdata_o <= rdata_d;
            rtc_wr_o <= rtc_wr_d;
            cap_half_pf_o <= cap_out_d;
            pin_ctl_q <= pin_ctl_d;
        end
    end

    assign counting_o = counting_q;
    assign osc_disable_o = osc_off_q;
    assign backup_o = on_backup_q;
    assign alarm_en_o = ev_q[`EV_GATE];

    ////////////////////////////////////////////////////////////////////
    // oscillator domain: reset release, control crossing, divider, pin
    logic orst_m_q, orst_s_q;
    pin_ctl_t ctl_m_q, ctl_s_q;
    logic rl_m_q, rl_s_q, rl_p_q;
    logic [`DIV_W-1:0] div_q, div_d;
    logic [15:0] trim_q, trim_d;
    logic [1:0] inc;
    logic [16:0] sum;
    logic trim_hit, tick_d, pin_d, oe_d;

    always_ff @(posedge osc_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            orst_m_q <= 1'b0;
            orst_s_q <= 1'b0;
        end else begin
            orst_m_q <= 1'b1;
            orst_s_q <= orst_m_q;
        end
    end

    always_comb begin
        trim_hit = ctl_s_q.rate[1:0] != 2'h0
            && trim_q == trim_period(ctl_s_q.rate[1:0]) - 16'h0001;
        trim_d = trim_hit ? 16'h0000 : trim_q + 16'h0001;
        inc = 2'h0;
        if (ctl_s_q.run) begin
            inc = trim_hit ? (ctl_s_q.rate[2] ? 2'h0 : 2'h2) : 2'h1;
        end
        sum = {1'b0, div_q[15:0]} + {15'h0000, inc};
        tick_d = sum[`TICK_BIT];
        div_d = div_q + `DIV_W'(inc);
        if (rl_s_q != rl_p_q) begin
            div_d = '0;
            trim_d = 16'h0000;
            tick_d = 1'b0;
        end
        if (ctl_s_q.off) begin
            pin_d = 1'b1;
            oe_d = 1'b0;
        end else if (ctl_s_q.fsel != 4'h0) begin
            pin_d = div_q[freq_bit(ctl_s_q.fsel)];
            oe_d = 1'b1;
        end else begin
            pin_d = 1'b0;
            oe_d = ctl_s_q.lvl;
        end
    end

    always_ff @(posedge osc_clk_i or negedge orst_s_q) begin
        if (!orst_s_q) begin
            ctl_m_q <= '0;
            ctl_s_q <= '0;
            rl_m_q <= 1'b0;
            rl_s_q <= 1'b0;
            rl_p_q <= 1'b0;
            div_q <= '0;
            trim_q <= 16'h0000;
            sec_tick_o <= 1'b0;
            pin_o <= 1'b1;
            pin_oe_o <= 1'b0;
        end else begin
            ctl_m_q <= pin_ctl_q;
            ctl_s_q <= ctl_m_q;
            rl_m_q <= rl_tog_q;
            rl_s_q <= rl_m_q;
            rl_p_q <= rl_s_q;
            div_q <= div_d;
            trim_q <= trim_d;
            sec_tick_o <= tick_d;
            pin_o <= pin_d;
            pin_oe_o <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_wr_then_stop;
        wr_rtc ##[1:1000] stop_wr;
    endsequence

    a_pf_boot: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(boot_done_q) |-> pf_q == $past(sup_s_q.all_lost))
        else $error("power fail flag not caught at boot");
    a_pf_no_set: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $past(boot_done_q) && !$past(pf_q) |-> !pf_q)
        else $error("power fail flag set while running");
    a_pf_halts: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        boot_done_q && pf_q |-> !counting_q)
        else $error("counting while power fail flag set");
    a_pf_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_rtc |=> !pf_q && rtc_wr_o)
        else $error("clock write left power fail flag set");
    a_bat_entry: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(on_backup_q) |-> bat_q)
        else $error("backup entry did not set flag");
    a_flag_no_wset: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(match_q) |-> $past(match_set))
        else $error("match flag set without a match");
    a_match_set: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        match_set |=> match_q)
        else $error("enabled match did not set flag");
    a_read_hit_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        stop_rd && hit_in_read_q |=> match_q)
        else $error("match during status read was lost");
    a_wr_locked: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr <= `ADDR_RTC_LAST && !wr_en_q |=> !rtc_wr_o)
        else $error("clock write accepted while locked");
    a_start_stop: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_wr_then_stop |=> counting_q && rl_tog_q != $past(rl_tog_q))
        else $error("stop after clock write did not start and realign");
    a_auto_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        stop_rd && auto_q && !bat_set |=> !bat_q)
        else $error("auto clear left backup flag set");
    a_pulse_len: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        match_set && ev_q[`EV_REPEAT] |=> pulse_q == `PULSE_W'(PULSE_CYC))
        else $error("repeat pulse not loaded to full width");
    a_hold_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        alarm_en_c && !ev_q[`EV_REPEAT] && match_q |=> pin_ctl_q.lvl)
        else $error("single alarm level not held");
    a_pin_off: assert property (@(posedge osc_clk_i) disable iff (!orst_s_q)
        ctl_s_q.off |=> !pin_oe_o && pin_o)
        else $error("pin driven while off on backup");
    a_fout_drive: assert property (@(posedge osc_clk_i) disable iff (!orst_s_q)
        !ctl_s_q.off && ctl_s_q.fsel != 4'h0 |=> pin_oe_o)
        else $error("frequency output not driving pin");

endmodule : rtc_control_status_trim
`default_nettype wire

// file: src/rtc_map.svh
/*
 offsets, field positions, reset values and timing counts of the rtc
 control, status and trim block.
 assumes inclusion by the block only.
*/
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// Contract
// - power fail flag reads 1 at power-up after both supplies were lost
// - losing only one supply leaves the power fail flag as it was
// - after total failure registers default and counters halt until a clock write
// - first accepted clock write after total failure clears the power fail flag
// - entering backup sets its flag; host writes only clear backup or match flags
// - enabled alarm match sets match flag; held until host or auto clear
// - match arriving during a status read survives that read's auto clear; a match arriving in the read request cycle itself is cleared
// - clock writes accepted only while write enable bit 4 is 1, reset 0
// - stop ending accepted clock write starts counting and realigns second tick
// - osc disable 1 stops crystal, counters run from external input; resets 0
// - auto clear 1 clears backup and match flags after status read and stop
// - frequency select picks pin output from off through 32768 Hz to 1/32 Hz
// - nonzero frequency select takes the pin and disables the alarm
// - pin off on backup bit disables the shared pin while on backup power
// - low power 0 needs both battery and trip compare; 1 only battery
// - alarm gate 1 lets matches raise alarms, 0 blocks them
// - repeat mode gives one 250 ms low pulse per alarm match
// - single mode holds pin low from match until match flag clears
// - load cap equals 16 inverted bit5 plus 8,4,2,1,0.5 weights plus 9 pF
// - backup cap offset adds none, -0.5, +0.5 or +1 pF on backup
// - rate trim sign bit 2, bit 1 weighs 40 ppm, bit 0 20 ppm
// - alarm byte msb enables that field in the match
`define ADDR_RTC_LAST 5'h06
`define ADDR_STATUS 5'h07
`define ADDR_EVENT 5'h08
`define ADDR_CAPTRIM 5'h0A
`define ADDR_RATETRIM 5'h0B
`define SR_POWER_FAIL 0
`define SR_BACKUP 1
`define SR_MATCH 2
`define SR_WR_EN 4
`define SR_OSC_OFF 6
`define SR_AUTO_CLR 7
`define EV_REPEAT 7
`define EV_GATE 6
`define EV_LOW_PWR 5
`define EV_PIN_OFF 4
`define REG_RESET 8'h00
`define CORE_HZ 10000000
`define PULSE_MS 250
`define PULSE_CYC ((`CORE_HZ / 1000) * `PULSE_MS)
`define PULSE_W 22
`define OSC_HZ 65536
`define DIV_W 21
`define TICK_BIT 16
`define TRIM_UNIT_CNT 50000
`define CAP_BASE_HALF 18
`endif

// file: src/rtc_pkg.sv
/*
 types shared by the rtc control, status and trim block.
 assumes the map header is on the include path.
*/
`default_nettype none
package rtc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic vdd_below_bat;
        logic vdd_below_trip;
        logic all_lost;
    } supply_t;
    typedef struct packed {
        logic [3:0] fsel;
        logic off;
        logic lvl;
        logic run;
        logic [2:0] rate;
    } pin_ctl_t;
    typedef enum logic [1:0] {X_IDLE, X_RD_SR, X_WR_RTC} xact_t;
endpackage : rtc_pkg
`default_nettype wire

// file: test/host_side.sv
/*
 register host model: byte writes and reads, then a stop pulse.
 assumes the core clock and the request port of the control block.
*/
`default_nettype none
module host_side
    import rtc_pkg::*;
(
    input wire logic core_clk_i,
    output var reg_req_t req_o,
    output var logic stop_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_o = '0;
        stop_o = 1'b0;
    end
    // one byte per request, held for one edge, then strobes cleared and address and data inverted while idle
    task automatic put(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put
    task automatic stop();
        @(posedge core_clk_i);
        stop_o <= 1'b1;
        @(posedge core_clk_i);
        stop_o <= 1'b0;
    endtask : stop
endmodule : host_side
`default_nettype wire

// file: test/tb.sv
/*
 self-checking bench of the rtc control, status and trim block.
 assumes the package, the map header and the host model are compiled first.
*/
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import rtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0, osc_clk = 1'b0, rstn_i = 1'b0, hit_q = 1'b0;
    supply_t supply = '{1'b0, 1'b0, 1'b1};
    reg_req_t req;
    logic stop, rtc_wr, counting, osc_dis, backup, alm_en, pin, pin_oe;
    logic [7:0] rdata, rv;
    logic [6:0] cap;
    int n_errors = 0, total_checks = 0, cyc = 0;
    always #50 core_clk_i = ~core_clk_i;
    initial begin
        #13;
        forever #32 osc_clk = ~osc_clk;
    end
    host_side host (.core_clk_i(core_clk_i), .req_o(req), .stop_o(stop));
    rtc_control_status_trim #(.PULSE_CYC(50)) DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .osc_clk_i(osc_clk), .req_i(req), .stop_i(stop), .alarm_hit_i(hit_q), .supply_i(supply),
        .rdata_o(rdata), .rtc_wr_o(rtc_wr), .counting_o(counting), .osc_disable_o(osc_dis),
        .backup_o(backup), .alarm_en_o(alm_en), .cap_half_pf_o(cap), .sec_tick_o(),
        .pin_o(pin), .pin_oe_o(pin_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.put(1'b1, a, d);
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        host.put(1'b0, a, 8'h00);
        #1 rv = rdata;
    endtask : rd
    task automatic hit();
        @(posedge core_clk_i);
        hit_q <= 1'b1;
        @(posedge core_clk_i);
        hit_q <= 1'b0;
    endtask : hit
    task automatic wait_oe(input logic v);
        for (int i = 0; i < 80 && pin_oe !== v; i++) @(posedge core_clk_i);
        #1;
    endtask : wait_oe
    function automatic logic [6:0] cx(input logic [5:0] c, input logic [1:0] o, input logic b);
        cx = 7'(18 + 32 * !c[5] + 16 * c[4] + 8 * c[3] + 4 * c[2] + 2 * c[1] + c[0]);
        if (b) cx = cx + ((o == 2'd1) ? 7'h7F : (o == 2'd2) ? 7'h01 : (o == 2'd3) ? 7'h02 : 7'h00);
    endfunction : cx
    ////////////////////////////////////////////////////////////////////////
    task automatic s_boot_and_clock();
        rd(5'h07);
        `CHK(rv, 8'h01)
        host.stop();
        `CHK({counting, osc_dis}, 2'b00)
        host.put(1'b1, 5'h00, 8'h12);
        #1 `CHK(rtc_wr, 1'b0)
        wr(5'h07, 8'h10);
        rd(5'h07);
        `CHK(rv, 8'h11)
        host.stop();
        host.put(1'b1, 5'h06, 8'h03);
        #1 `CHK(rtc_wr, 1'b1)
        host.stop();
        @(posedge core_clk_i);
        #1 `CHK(counting, 1'b1)
        rd(5'h07);
        `CHK(rv, 8'h10)
    endtask : s_boot_and_clock
    task automatic s_backup();
        supply <= '{1'b1, 1'b0, 1'b0};
        repeat (10) @(posedge core_clk_i);
        #1 `CHK(backup, 1'b0)
        wr(5'h08, 8'h20);
        repeat (4) @(posedge core_clk_i);
        #1 `CHK(backup, 1'b1)
        for (int o = 0; o < 4; o++) begin
            wr(5'h0A, {o[1:0], 6'h00});
            `CHK(cap, cx(6'h00, o[1:0], 1'b1))
        end
        wr(5'h07, 8'h92);
        rd(5'h07);
        `CHK(rv, 8'h92)
        host.stop();
        rd(5'h07);
        `CHK(rv, 8'h90)
        wr(5'h07, 8'h10);
        wr(5'h08, 8'h31);
        repeat (60) @(posedge core_clk_i);
        #1 `CHK(pin_oe, 1'b0)
        supply <= '{1'b0, 1'b0, 1'b0};
        wait_oe(1'b1);
        `CHK(pin_oe, 1'b1)
    endtask : s_backup
    task automatic s_trim();
        logic [5:0] codes[5] = '{6'h00, 6'h20, 6'h1F, 6'h3F, 6'h01};
        foreach (codes[i]) begin
            wr(5'h0A, {2'b11, codes[i]});
            `CHK(cap, cx(codes[i], 2'b11, 1'b0))
        end
        wr(5'h0B, 8'hFF);
        rd(5'h0B);
        `CHK(rv, 8'h07)
        wr(5'h0B, 8'h00);
        wr(5'h07, 8'h50);
        `CHK(osc_dis, 1'b1)
        wr(5'h07, 8'h10);
    endtask : s_trim
    task automatic s_freq(input logic [3:0] f, input int n, input int e);
        int t;
        logic p;
        wr(5'h08, {4'h0, f});
        repeat (40) @(posedge core_clk_i);
        t = 0;
        @(posedge osc_clk);
        #1 p = pin;
        repeat (n) begin
            @(posedge osc_clk);
            #1 if (pin !== p) t++;
            p = pin;
        end
        `CHK(pin_oe, 1'b1)
        `CHK(t, e)
    endtask : s_freq
    task automatic s_alarm();
        int n;
        wr(5'h08, 8'h40);
        `CHK(alm_en, 1'b1)
        hit();
        wait_oe(1'b1);
        `CHK({pin_oe, pin}, 2'b10)
        rd(5'h07);
        `CHK(rv, 8'h14)
        repeat (100) @(posedge core_clk_i);
        #1 `CHK(pin_oe, 1'b1)
        wr(5'h07, 8'h90);
        wait_oe(1'b0);
        `CHK(pin_oe, 1'b0)
        fork
            host.put(1'b0, 5'h07, 8'h00);
            hit();
        join
        host.stop();
        rd(5'h07);
        `CHK(rv, 8'h94)
        host.stop();
        rd(5'h07);
        `CHK(rv, 8'h90)
        wr(5'h07, 8'h10);
        wr(5'h08, 8'h00);
        hit();
        rd(5'h07);
        `CHK(rv, 8'h10)
        wr(5'h08, 8'h41);
        hit();
        rd(5'h07);
        `CHK(rv, 8'h10)
        wr(5'h08, 8'hC0);
        repeat (2) begin
            hit();
            wait_oe(1'b1);
            n = 0;
            while (pin_oe === 1'b1 && n < 200) begin
                @(posedge core_clk_i);
                n++;
            end
            `CHK(n >= 45 && n <= 56, 1'b1)
        end
    endtask : s_alarm
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        s_boot_and_clock();
        s_backup();
        s_trim();
        s_freq(4'h1, 256, 256);
        s_freq(4'h2, 256, 32);
        s_freq(4'h3, 256, 8);
        s_freq(4'h4, 1024, 2);
        s_alarm();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
